// [hw/board_misc_pins.sv]
// Purpose: Board-side logic driving the bridge clear, ring and modem inputs
// Assumes: Same mclk domain; device pins sampled through three flops
// Notes:   Wake pulse is stretched beyond the qualify time
`timescale 1ns/1ns
module board_misc_pins
    import misc_pins_pkg::*;
#(
    parameter int unsigned WAKE_CYC = WAKE_PULSE_CYC
)
(
    input  wire logic   mclk,
    input  wire logic   rst_b,
    misc_pins_if.board  pins,
    input  wire logic   clear_req,
    input  wire logic   wake_req,
    input  wire logic   tx_bit,
    input  wire logic   cts_n,
    input  wire logic   dsr_n,
    input  wire logic   dcd_n,
    output logic        wake_busy,
    output logic        hold_seen_n,
    output logic        rx_bit
);
    logic [CNT_W-1:0] pulse_cnt_r;
    logic             clear_r;
    logic             ring_r;
    logic             busy_r;
    logic [1:0]       hold_sync_r;
    logic [1:0]       rx_sync_r;
    logic             hold_r;
    logic             rxb_r;
    logic             out_r;
    logic [2:0]       ms_r;

    wire hold_level = pins.por_hold_oe_n | pins.por_hold_out;
    wire pulse_end  = pulse_cnt_r == CNT_W'(WAKE_CYC + 2);

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pulse_cnt_r <= '0;
            clear_r     <= 1'b1;
            ring_r      <= 1'b1;
            busy_r      <= 1'b0;
            hold_sync_r <= 2'h3;
            rx_sync_r   <= 2'h3;
            hold_r      <= 1'b1;
            rxb_r       <= 1'b1;
            out_r       <= 1'b1;
            ms_r        <= 3'h7;
        end
        else
        begin
            clear_r <= ~clear_req;
            if (wake_req && !busy_r)
            begin
                busy_r      <= 1'b1;
                ring_r      <= 1'b0;
                pulse_cnt_r <= '0;
            end
            else if (busy_r)
            begin
                pulse_cnt_r <= pulse_cnt_r + 1'b1;
                if (pulse_end)
                begin
                    busy_r <= 1'b0;
                    ring_r <= 1'b1;
                end
            end
            hold_sync_r <= {hold_sync_r[0], hold_level};
            rx_sync_r   <= {rx_sync_r[0], pins.serial_tx};
            hold_r      <= hold_sync_r[1];
            rxb_r       <= rx_sync_r[1];
            out_r       <= tx_bit;
            ms_r        <= {cts_n, dsr_n, dcd_n};
        end
    end

    assign pins.clear_in_n          = clear_r;
    assign pins.ring_wake_in_n      = ring_r;
    assign pins.test_mode_in        = 1'b0;
    assign pins.osc_ref_in          = 1'b0;
    assign pins.serial_rx           = out_r;
    assign pins.cts_in_n            = ms_r[2];
    assign pins.dsr_in_n            = ms_r[1];
    assign pins.carrier_detect_in_n = ms_r[0];
    assign wake_busy                = busy_r;
    assign hold_seen_n              = hold_r;
    assign rx_bit                   = rxb_r;
endmodule // board_misc_pins

// [hw/bridge_misc_pins.sv]
// Purpose: Reset output, lamps, suspend pins and ring wake of the bridge
// Assumes: mclk is the internal clock; rst_b is power-on reset
// Notes:   USB engine and UART core are outside; they give pulses and levels
`timescale 1ns/1ns
module bridge_misc_pins
    import misc_pins_pkg::*;
#(
    parameter int unsigned POR_CYC    = POR_HOLD_CYC,
    parameter int unsigned WAKE_CYC   = WAKE_PULSE_CYC,
    parameter int unsigned LAMP_CYCLES = LAMP_CYC,
    parameter int unsigned RESUME_CYCLES = RESUME_CYC
)
(
    input  wire logic   mclk,
    input  wire logic   rst_b,
    misc_pins_if.device pins,
    input  wire logic   usb_bus_reset,
    input  wire logic   usb_tx_pulse,
    input  wire logic   usb_rx_pulse,
    input  wire logic   usb_suspend,
    input  wire logic   usb_configured,
    input  wire logic   remote_wake_en,
    input  wire logic   uart_tx_data,
    input  wire logic   uart_tx_busy,
    input  wire logic   uart_rts_n,
    input  wire logic   uart_dtr_n,
    output logic        uart_rx_data,
    output logic [3:0]  modem_status_n,
    output logic        resume_req,
    output logic        test_mode
);
    typedef enum logic [1:0] {POR_FLOAT, POR_DRIVE, POR_CLAMP} por_state_e;

    por_state_e       por_r;
    logic [CNT_W-1:0] por_cnt_r;
    logic [CNT_W-1:0] send_cnt_r;
    logic [CNT_W-1:0] recv_cnt_r;
    logic [CNT_W-1:0] wake_cnt_r;
    logic [CNT_W-1:0] res_cnt_r;
    logic [1:0]       clr_sync_r;
    logic [1:0]       ring_sync_r;
    logic [1:0]       test_sync_r;
    logic [1:0]       rx_sync_r;
    logic [3:0]       ms_s1_r;
    logic [3:0]       ms_s2_r;
    logic             osc_r;
    logic             send_lamp_r;
    logic             recv_lamp_r;
    logic             hold_out_r;
    logic             hold_oe_n_r;
    logic             ring_armed_r;
    logic             line_drv_r;
    logic             rts_r;
    logic             dtr_r;
    logic             tx_r;
    logic             susp_n_r;
    logic             pwr_n_r;
    logic             resume_r;
    logic             rx_r;
    logic             test_r;

    function automatic logic [CNT_W-1:0] lamp_next(input logic hit,
                                                   input logic [CNT_W-1:0] cnt);
        if (hit)
            lamp_next = CNT_W'(LAMP_CYCLES);
        else if (cnt != '0)
            lamp_next = cnt - 1'b1;
        else
            lamp_next = '0;
    endfunction

    wire clear_now   = ~clr_sync_r[1];
    wire ring_low    = ~ring_sync_r[1];
    wire wake_done   = wake_cnt_r == CNT_W'(WAKE_CYC);
    wire wake_fire   = wake_done & ring_armed_r & usb_suspend & remote_wake_en;
    wire por_expired = por_cnt_r == CNT_W'(POR_CYC);

    // usb_bus_reset deliberately unused by the reset output path
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            por_r       <= POR_FLOAT;
            por_cnt_r   <= '0;
            hold_out_r  <= 1'b0;
            hold_oe_n_r <= 1'b1;
        end
        else
        begin
            case (por_r)
                POR_FLOAT:
                begin
                    hold_oe_n_r <= 1'b1;
                    if (clear_now)
                        por_r <= POR_CLAMP;
                    else if (por_expired)
                        por_r <= POR_DRIVE;
                    else
                        por_cnt_r <= por_cnt_r + 1'b1;
                end
                POR_DRIVE:
                begin
                    hold_out_r  <= 1'b1;
                    hold_oe_n_r <= 1'b0;
                    if (clear_now)
                        por_r <= POR_CLAMP;
                end
                POR_CLAMP:
                begin
                    hold_out_r  <= 1'b0;
                    hold_oe_n_r <= 1'b0;
                    if (!clear_now)
                        por_r <= POR_DRIVE;
                end
                default: por_r <= POR_FLOAT;
            endcase
        end
    end

    // Synchronisers: first stage feeds only the second
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            clr_sync_r  <= 2'h3;
            ring_sync_r <= 2'h3;
            test_sync_r <= 2'h0;
            rx_sync_r   <= 2'h3;
            ms_s1_r     <= 4'hF;
            ms_s2_r     <= 4'hF;
        end
        else
        begin
            clr_sync_r  <= {clr_sync_r[0], pins.clear_in_n};
            ring_sync_r <= {ring_sync_r[0], pins.ring_wake_in_n};
            test_sync_r <= {test_sync_r[0], pins.test_mode_in};
            rx_sync_r   <= {rx_sync_r[0], pins.serial_rx};
            ms_s1_r     <= {pins.cts_in_n, pins.dsr_in_n,
                            pins.carrier_detect_in_n, pins.ring_wake_in_n};
            ms_s2_r     <= ms_s1_r;
        end
    end

    // Ring must be seen high again before a second resume; avoids repeats
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wake_cnt_r   <= '0;
            ring_armed_r <= 1'b1;
            res_cnt_r    <= '0;
            resume_r     <= 1'b0;
        end
        else
        begin
            if (!ring_low)
                wake_cnt_r <= '0;
            else if (!wake_done)
                wake_cnt_r <= wake_cnt_r + 1'b1;
            if (!ring_low)
                ring_armed_r <= 1'b1;
            else if (wake_fire)
                ring_armed_r <= 1'b0;
            if (wake_fire)
                res_cnt_r <= CNT_W'(RESUME_CYCLES);
            else if (res_cnt_r != '0)
                res_cnt_r <= res_cnt_r - 1'b1;
            resume_r <= wake_fire | (res_cnt_r > CNT_W'(1));
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            send_cnt_r <= '0;
            recv_cnt_r <= '0;
            send_lamp_r <= 1'b1;
            recv_lamp_r <= 1'b1;
        end
        else
        begin
            send_cnt_r  <= lamp_next(usb_tx_pulse, send_cnt_r);
            recv_cnt_r  <= lamp_next(usb_rx_pulse, recv_cnt_r);
            send_lamp_r <= ~(usb_tx_pulse | (send_cnt_r > CNT_W'(1)));
            recv_lamp_r <= ~(usb_rx_pulse | (recv_cnt_r > CNT_W'(1)));
        end
    end

    // Oscillator output modelled as mclk/2, frozen in suspend
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            osc_r      <= 1'b0;
            line_drv_r <= 1'b0;
            rts_r      <= 1'b1;
            dtr_r      <= 1'b1;
            tx_r       <= 1'b1;
            susp_n_r   <= 1'b1;
            pwr_n_r    <= 1'b1;
            rx_r       <= 1'b1;
            test_r     <= 1'b0;
        end
        else
        begin
            if (!usb_suspend)
                osc_r <= ~osc_r;
            line_drv_r <= uart_tx_busy;
            rts_r      <= uart_rts_n;
            dtr_r      <= uart_dtr_n;
            tx_r       <= uart_tx_data;
            susp_n_r   <= ~usb_suspend;
            pwr_n_r    <= ~(usb_configured & ~usb_suspend);
            rx_r       <= rx_sync_r[1];
            test_r     <= test_sync_r[1];
        end
    end

    assign pins.por_hold_out            = hold_out_r;
    assign pins.por_hold_oe_n           = hold_oe_n_r;
    assign pins.send_activity_lamp_n    = 1'b0;
    assign pins.send_lamp_oe_n          = send_lamp_r;
    assign pins.receive_activity_lamp_n = 1'b0;
    assign pins.receive_lamp_oe_n       = recv_lamp_r;
    assign pins.osc_drive_out           = osc_r;
    assign pins.line_driver_on          = line_drv_r;
    assign pins.rts_out_n               = rts_r;
    assign pins.dtr_out_n               = dtr_r;
    assign pins.serial_tx               = tx_r;
    assign pins.suspend_out_n           = susp_n_r;
    assign pins.power_switch_enable_n   = pwr_n_r;
    assign uart_rx_data                 = rx_r;
    assign modem_status_n               = ms_s2_r;
    assign resume_req                   = resume_r;
    assign test_mode                    = test_r;
endmodule // bridge_misc_pins

// [pkg/misc_pins_if.sv]
// Purpose: Pin bundle between the bridge device and its board logic
// Assumes: Open-collector and tri-state pins split into in/out/enable
// Notes:   Enables are active low; the bench resolves wire levels
`timescale 1ns/1ns
interface misc_pins_if;
    logic clear_in_n;
    logic por_hold_out;
    logic por_hold_oe_n;
    logic por_hold_out_n;
    logic send_activity_lamp_n;
    logic send_lamp_oe_n;
    logic receive_activity_lamp_n;
    logic receive_lamp_oe_n;
    logic osc_ref_in;
    logic osc_drive_out;
    logic test_mode_in;
    logic ring_wake_in_n;
    logic line_driver_on;
    logic rts_out_n;
    logic dtr_out_n;
    logic cts_in_n;
    logic dsr_in_n;
    logic carrier_detect_in_n;
    logic ring_in_n;
    logic serial_tx;
    logic serial_rx;
    logic suspend_out_n;
    logic power_switch_enable_n;

    modport device (
        input  clear_in_n, osc_ref_in, test_mode_in, ring_wake_in_n, cts_in_n,
               dsr_in_n, carrier_detect_in_n, serial_rx,
        output por_hold_out, por_hold_oe_n, send_activity_lamp_n, send_lamp_oe_n,
               receive_activity_lamp_n, receive_lamp_oe_n, osc_drive_out,
               line_driver_on, rts_out_n, dtr_out_n, serial_tx, suspend_out_n,
               power_switch_enable_n
    );
    modport board (
        output clear_in_n, osc_ref_in, test_mode_in, ring_wake_in_n, cts_in_n,
               dsr_in_n, carrier_detect_in_n, serial_rx,
        input  por_hold_out, por_hold_oe_n, send_activity_lamp_n, send_lamp_oe_n,
               receive_activity_lamp_n, receive_lamp_oe_n, osc_drive_out,
               line_driver_on, rts_out_n, dtr_out_n, serial_tx, suspend_out_n,
               power_switch_enable_n
    );
endinterface

// [pkg/misc_pins_pkg.sv]
// Purpose: Shared constants for the bridge miscellaneous pin logic
// Assumes: Single 25 MHz clock, times converted to cycles here
// Notes:   Long counts are also top-level parameters
package misc_pins_pkg;
    localparam int unsigned CLK_HZ          = 25000000;
    localparam int unsigned POR_HOLD_MS     = 5;
    localparam int unsigned WAKE_PULSE_MS   = 20;
    localparam int unsigned LAMP_MS         = 50;
    localparam int unsigned RESUME_MS       = 10;
    localparam int unsigned REF_HZ          = 6000000;
    localparam int unsigned POR_HOLD_CYC    = POR_HOLD_MS * (CLK_HZ / 1000);
    localparam int unsigned WAKE_PULSE_CYC  = WAKE_PULSE_MS * (CLK_HZ / 1000);
    localparam int unsigned LAMP_CYC        = LAMP_MS * (CLK_HZ / 1000);
    localparam int unsigned RESUME_CYC      = RESUME_MS * (CLK_HZ / 1000);
    localparam int unsigned CNT_W           = 24;
    localparam logic [1:0]  PIN_HIZ         = 2'h0;
    localparam logic [1:0]  PIN_LOW         = 2'h1;
    localparam logic [1:0]  PIN_HIGH        = 2'h2;
    localparam logic        SUSPEND_RST     = 1'h0;
endpackage

// [testbench/misc_pins_properties.sv]
// Purpose: Concurrent checks on the bridge-to-board pin bundle
// Assumes: One mclk domain, rst_b async active low
// Notes:   Counts follow the parameters handed in by the bench
`timescale 1ns/1ns
module misc_pins_properties
#(
    parameter int unsigned POR_CYC  = 20,
    parameter int unsigned WAKE_CYC = 30
)
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clear_in_n,
    input wire logic por_hold_out,
    input wire logic por_hold_oe_n,
    input wire logic send_activity_lamp_n,
    input wire logic send_lamp_oe_n,
    input wire logic receive_activity_lamp_n,
    input wire logic receive_lamp_oe_n,
    input wire logic osc_drive_out,
    input wire logic ring_wake_in_n,
    input wire logic suspend_out_n,
    input wire logic power_switch_enable_n
);
    logic [15:0] por_cnt_r;
    logic [15:0] por_cnt_nxt;
    logic [15:0] ring_cnt_r;
    logic [15:0] ring_cnt_nxt;
    logic        por_done;

    // Saturates at POR_CYC + 2 so por_done stays set once reached after release
    assign por_done     = (por_cnt_r == 16'(POR_CYC + 2));
    assign por_cnt_nxt  = por_done ? por_cnt_r : por_cnt_r + 16'h1;
    assign ring_cnt_nxt = ring_wake_in_n ? 16'h0 : ring_cnt_r + 16'h1;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            por_cnt_r  <= 16'h0;
            ring_cnt_r <= 16'h0;
        end
        else
        begin
            por_cnt_r  <= por_cnt_nxt;
            ring_cnt_r <= ring_cnt_nxt;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    AST_POR_FLOAT: assert property (
        (por_cnt_r <= 16'(POR_CYC) && clear_in_n) |-> por_hold_oe_n)
        else $error("reset output driven before hold time");
    AST_POR_DRIVE: assert property (
        clear_in_n[*5] ##0 por_done |-> (!por_hold_oe_n && por_hold_out))
        else $error("reset output not driven high");
    AST_CLEAR_LOW: assert property (
        !clear_in_n[*5] |-> (!por_hold_oe_n && !por_hold_out))
        else $error("clear input did not pull reset output low");
    AST_SEND_LAMP: assert property (
        $fell(send_lamp_oe_n) |-> (!send_lamp_oe_n && !send_activity_lamp_n)[*8])
        else $error("send lamp pulse too short");
    AST_RECV_LAMP: assert property (
        $fell(receive_lamp_oe_n) |-> (!receive_lamp_oe_n && !receive_activity_lamp_n)[*8])
        else $error("receive lamp pulse too short");
    AST_OSC_RUN: assert property (
        (por_cnt_r > 16'h2 && suspend_out_n && $past(suspend_out_n, 2))
            |-> (osc_drive_out != $past(osc_drive_out)))
        else $error("oscillator output not toggling");
    AST_OSC_HOLD: assert property (
        (!suspend_out_n && !$past(suspend_out_n)) |-> $stable(osc_drive_out))
        else $error("oscillator output toggles in suspend");
    AST_PWR_SUSP: assert property (
        !suspend_out_n |-> power_switch_enable_n)
        else $error("power enable active in suspend");
    AST_RING_WIDTH: assert property (
        (ring_wake_in_n && ring_cnt_r != 16'h0) |-> (ring_cnt_r > 16'(WAKE_CYC)))
        else $error("ring wake pulse shorter than qualify time");
endmodule // misc_pins_properties

// [testbench/tb.sv]
// Purpose: Bench joining bridge and board ends through the pin bundle
// Assumes: Short counts stand in for the millisecond figures
// Notes:   Reset output wire has a pull-up, so float reads high
`timescale 1ns/1ns
module tb;
    localparam int POR  = 20;
    localparam int WAKE = 30;
    localparam int LAMP = 10;
    localparam int RES  = 8;

    logic       mclk;
    logic       rst_b;
    logic       usb_bus_reset;
    logic [1:0] lamp_pulse;
    logic       usb_suspend;
    logic       usb_configured;
    logic       remote_wake_en;
    logic       uart_tx_data;
    logic       uart_tx_busy;
    logic       uart_rts_n;
    logic       uart_dtr_n;
    logic       uart_rx_data;
    logic [3:0] modem_status_n;
    logic       resume_req;
    logic       test_mode;
    logic       clear_req;
    logic       wake_req;
    logic       tx_bit;
    logic       cts_n;
    logic       dsr_n;
    logic       dcd_n;
    logic       wake_busy;
    logic       hold_seen_n;
    logic       rx_bit;
    logic       v;
    logic       osc_seen;
    logic       res_seen;
    logic [1:0] lamp_oe_n;
    int         num_errors;
    int         checked;
    int         n;

    misc_pins_if pins();
    assign pins.por_hold_out_n = pins.por_hold_oe_n ? 1'b1 : pins.por_hold_out;
    assign lamp_oe_n = {pins.receive_lamp_oe_n, pins.send_lamp_oe_n};

    bridge_misc_pins #(.POR_CYC(POR), .WAKE_CYC(WAKE), .LAMP_CYCLES(LAMP),
        .RESUME_CYCLES(RES)) bridge_misc_pins_i (.mclk(mclk), .rst_b(rst_b),
        .pins(pins.device), .usb_bus_reset(usb_bus_reset), .usb_tx_pulse(lamp_pulse[0]),
        .usb_rx_pulse(lamp_pulse[1]), .usb_suspend(usb_suspend),
        .usb_configured(usb_configured), .remote_wake_en(remote_wake_en),
        .uart_tx_data(uart_tx_data), .uart_tx_busy(uart_tx_busy),
        .uart_rts_n(uart_rts_n), .uart_dtr_n(uart_dtr_n), .uart_rx_data(uart_rx_data),
        .modem_status_n(modem_status_n), .resume_req(resume_req), .test_mode(test_mode));
    board_misc_pins #(.WAKE_CYC(WAKE)) board_misc_pins_i (.mclk(mclk), .rst_b(rst_b),
        .pins(pins.board), .clear_req(clear_req), .wake_req(wake_req), .tx_bit(tx_bit),
        .cts_n(cts_n), .dsr_n(dsr_n), .dcd_n(dcd_n), .wake_busy(wake_busy),
        .hold_seen_n(hold_seen_n), .rx_bit(rx_bit));
    misc_pins_properties #(.POR_CYC(POR), .WAKE_CYC(WAKE)) misc_pins_properties_i (
        .mclk(mclk), .rst_b(rst_b), .clear_in_n(pins.clear_in_n),
        .por_hold_out(pins.por_hold_out), .por_hold_oe_n(pins.por_hold_oe_n),
        .send_activity_lamp_n(pins.send_activity_lamp_n),
        .send_lamp_oe_n(pins.send_lamp_oe_n),
        .receive_activity_lamp_n(pins.receive_activity_lamp_n),
        .receive_lamp_oe_n(pins.receive_lamp_oe_n), .osc_drive_out(pins.osc_drive_out),
        .ring_wake_in_n(pins.ring_wake_in_n), .suspend_out_n(pins.suspend_out_n),
        .power_switch_enable_n(pins.power_switch_enable_n));

    task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic step(input int cnt);
        repeat (cnt) @(negedge mclk);
    endtask

    // Entered at the negedge that releases reset
    task automatic por_check();
        step(POR);
        check("hold float", 4'(pins.por_hold_oe_n), 4'h1);
        step(2);
        check("hold wire high", 4'(pins.por_hold_out_n), 4'h1);
        check("hold driven", 4'(pins.por_hold_oe_n), 4'h0);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    initial
    begin
        repeat (5000) @(posedge mclk);
        num_errors++;
        give_verdict();
    end

    initial
    begin
        {rst_b, usb_bus_reset, lamp_pulse, usb_suspend, usb_configured} = 6'h0;
        {remote_wake_en, uart_tx_data, uart_tx_busy, clear_req, wake_req} = 5'h0;
        {uart_rts_n, uart_dtr_n, tx_bit, cts_n, dsr_n, dcd_n} = 6'h3F;
        step(8);
        rst_b = 1'b1;
        por_check();
        usb_bus_reset = 1'b1;
        step(4);
        check("hold in bus reset", 4'(pins.por_hold_out_n), 4'h1);
        usb_bus_reset = 1'b0;
        clear_req = 1'b1;
        step(5);
        check("hold wire clear", 4'(pins.por_hold_out_n), 4'h0);
        step(3);
        check("hold seen clear", 4'(hold_seen_n), 4'h0);
        clear_req = 1'b0;
        step(5);
        check("hold wire back", 4'(pins.por_hold_out_n), 4'h1);
        for (int i = 0; i < 2; i++)
        begin
            lamp_pulse = 2'(1 << i);
            step(1);
            lamp_pulse = 2'h0;
            check("lamp on", 4'(lamp_oe_n), {2'h0, ~(2'h1 << i)});
            step(4);
            lamp_pulse = 2'(1 << i);
            step(1);
            lamp_pulse = 2'h0;
            step(6);
            check("lamp extended", 4'(lamp_oe_n), {2'h0, ~(2'h1 << i)});
            step(5);
            check("lamp off", 4'(lamp_oe_n), 4'h3);
        end
        usb_configured = 1'b1;
        step(2);
        check("power on", 4'(pins.power_switch_enable_n), 4'h0);
        check("awake", 4'(pins.suspend_out_n), 4'h1);
        osc_seen = pins.osc_drive_out;
        step(1);
        check("osc run", 4'(pins.osc_drive_out), {3'h0, ~osc_seen});
        usb_suspend = 1'b1;
        step(2);
        check("asleep", 4'(pins.suspend_out_n), 4'h0);
        check("power off", 4'(pins.power_switch_enable_n), 4'h1);
        osc_seen = pins.osc_drive_out;
        step(3);
        check("osc held", 4'(pins.osc_drive_out), 4'(osc_seen));
        // Wake enabled: resume only after a fully qualified low
        remote_wake_en = 1'b1;
        wake_req = 1'b1;
        step(1);
        wake_req = 1'b0;
        n = 0;
        while (resume_req !== 1'b1 && n < 200)
        begin
            step(1);
            n++;
        end
        check("resume late enough", 4'(n >= WAKE), 4'h1);
        check("resume", 4'(resume_req), 4'h1);
        n = 0;
        while (resume_req === 1'b1 && n < 50)
        begin
            step(1);
            n++;
        end
        check("resume length", 4'(n), 4'(RES));
        n = 0;
        while (wake_busy !== 1'b0 && n < 200)
        begin
            step(1);
            n++;
        end
        step(4);
        remote_wake_en = 1'b0;
        wake_req = 1'b1;
        step(1);
        wake_req = 1'b0;
        res_seen = 1'b0;
        repeat (80)
        begin
            step(1);
            res_seen = res_seen | resume_req;
        end
        check("no resume disabled", 4'(res_seen), 4'h0);
        usb_suspend = 1'b0;
        for (int i = 0; i < 2; i++)
        begin
            v = i[0];
            {uart_tx_data, uart_tx_busy, uart_rts_n, uart_dtr_n} = {v, v, ~v, v};
            {tx_bit, cts_n, dsr_n, dcd_n} = {~v, v, ~v, v};
            step(6);
            check("line driver", 4'(pins.line_driver_on), 4'(v));
            check("rts dtr", {2'h0, pins.rts_out_n, pins.dtr_out_n}, {2'h0, ~v, v});
            check("tx line", {2'h0, pins.serial_tx, rx_bit}, {2'h0, v, v});
            check("rx data", 4'(uart_rx_data), {3'h0, ~v});
            check("modem in", modem_status_n, {v, ~v, v, 1'b1});
        end
        check("test mode", 4'(test_mode), 4'h0);
        rst_b = 1'b0;
        step(3);
        check("hold float in reset", 4'(pins.por_hold_oe_n), 4'h1);
        rst_b = 1'b1;
        por_check();
        give_verdict();
    end
endmodule // tb
